/* inc/bpl_consts.svh */
// Constants for the bidirectional port lines block
`ifndef BPL_CONSTS_SVH
`define BPL_CONSTS_SVH
`define BPL_NPORTS    10
`define BPL_PW        16
`define BPL_NREGS     9
`define BPL_INPORT    5
`define BPL_REG_OUT   4'h0
`define BPL_REG_SET   4'h1
`define BPL_REG_CLR   4'h2
`define BPL_REG_DIR   4'h3
`define BPL_REG_ODC   4'h4
`define BPL_REG_PIN   4'h5
`define BPL_REG_THR   4'h6
`define BPL_REG_PAD   4'h7
`define BPL_REG_ALT   4'h8
`define BPL_REG_LSB   2
`define BPL_PORT_LSB  6
`define BPL_MAP_TOP   10
`define BPL_RST_WORD  16'h0000
`define BPL_OD_CAP    10'h3dc
`define BPL_THR_CAP   10'h1dc
`define BPL_LW        5
`define BPL_LINES     {5'd4, 5'd4, 5'd8, 5'd8, 5'd16, 5'd8, 5'd8, 5'd15, \
                       5'd16, 5'd16}
`endif

/* inc/bpl_pkg.sv */
// Shared types of the bidirectional port lines block
package bpl_pkg;
    typedef logic [15:0] bpl_word_t;
    typedef logic [3:0]  bpl_idx_t;
    typedef logic [8:0]  bpl_stb_t;
endpackage : bpl_pkg

/* logic/bpl_apb_decode.sv */
// APB address decode for the port register map
`timescale 1ns/1ns
`include "bpl_consts.svh"
module bpl_apb_decode #(
    parameter int AW = 12
) (
    input  wire logic [AW-1:0]        paddr,   // APB address
    input  wire logic                 psel,    // APB select
    input  wire logic                 penable, // APB access phase
    input  wire logic                 pwrite,  // APB direction
    output bpl_pkg::bpl_idx_t         port_idx, // Port number
    output bpl_pkg::bpl_idx_t         reg_idx,  // Register in port
    output logic                      hit,      // Mapped address
    output bpl_pkg::bpl_stb_t         wr_stb    // One-hot write
);
    // Map needs address bits up to the port field
    if (AW < `BPL_MAP_TOP)
    begin : g_aw_chk
        $error("bpl_apb_decode: AW too small");
    end

    // Word aligned, port below count, register below count
    logic upper_zero;
    assign upper_zero = (paddr >> `BPL_MAP_TOP) == '0;
    assign port_idx = paddr[`BPL_PORT_LSB +: 4];
    assign reg_idx  = paddr[`BPL_REG_LSB +: 4];
    assign hit = upper_zero && paddr[`BPL_REG_LSB-1:0] == 2'h0
               && port_idx < 4'(`BPL_NPORTS) && reg_idx < 4'(`BPL_NREGS);

    // Writes land only in the access phase
    assign wr_stb = (psel && penable && pwrite && hit)
                  ? bpl_pkg::bpl_stb_t'(9'h001 << reg_idx) : 9'h000;
endmodule : bpl_apb_decode

/* logic/bpl_port_slice.sv */
// One port: latches, direction, driver type, pad settings
`timescale 1ns/1ns
`include "bpl_consts.svh"
module bpl_port_slice #(
    parameter int LINES   = 16,
    parameter bit HAS_OD  = 1'b1,
    parameter bit HAS_THR = 1'b1,
    parameter bit IN_ONLY = 1'b0
) (
    input  wire logic                ref_clk, // System clock
    input  wire logic                arst_n,  // Async reset
    input  wire logic [8:0]          wr_stb,  // Write strobes
    input  wire bpl_pkg::bpl_word_t  wdata,   // Write data
    input  wire bpl_pkg::bpl_idx_t   rd_sel,  // Register to read
    input  wire bpl_pkg::bpl_word_t  pin_in,  // Pin levels
    input  wire bpl_pkg::bpl_word_t  alt_out, // Peripheral value
    input  wire bpl_pkg::bpl_word_t  alt_oe,  // Peripheral drive
    output bpl_pkg::bpl_word_t       rd_word, // Read data
    output bpl_pkg::bpl_word_t       pin_out, // Pad value
    output bpl_pkg::bpl_word_t       pin_oe,  // Pad enable
    output bpl_pkg::bpl_word_t       pin_q,   // Sampled pins
    output bpl_pkg::bpl_word_t       out_q,   // Output latch
    output bpl_pkg::bpl_word_t       dir_q,   // Direction
    output bpl_pkg::bpl_word_t       od_q,    // Open-drain select
    output bpl_pkg::bpl_word_t       alt_q,   // Alternate select
    output logic [1:0]               thr_q,   // Byte thresholds
    output bpl_pkg::bpl_word_t       pad_q    // Pad driver control
);
    if (LINES < 1 || LINES > `BPL_PW)
    begin : g_lines_chk
        $error("bpl_port_slice: LINES");
    end

    localparam bpl_pkg::bpl_word_t MASK = 16'((17'h1 << LINES) - 17'h1);
    localparam bpl_pkg::bpl_word_t DMSK = IN_ONLY ? 16'h0000 : MASK;
    localparam bpl_pkg::bpl_word_t OMSK = HAS_OD ? DMSK : 16'h0000;

    // Set and clear strobes touch only the bits written as one
    bpl_pkg::bpl_word_t out_nxt;
    assign out_nxt = wr_stb[`BPL_REG_OUT] ? wdata & DMSK
                   : wr_stb[`BPL_REG_SET] ? (out_q | wdata) & DMSK
                   : wr_stb[`BPL_REG_CLR] ? out_q & ~wdata
                   : out_q;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_q <= `BPL_RST_WORD;
            dir_q <= `BPL_RST_WORD;
            od_q  <= `BPL_RST_WORD;
            alt_q <= `BPL_RST_WORD;
            pad_q <= `BPL_RST_WORD;
            pin_q <= `BPL_RST_WORD;
            thr_q <= 2'h0;
        end
        else
        begin
            out_q <= out_nxt;
            pin_q <= pin_in & MASK;
            if (wr_stb[`BPL_REG_DIR]) dir_q <= wdata & DMSK;
            if (wr_stb[`BPL_REG_ODC]) od_q  <= wdata & OMSK;
            if (wr_stb[`BPL_REG_ALT]) alt_q <= wdata & MASK;
            if (wr_stb[`BPL_REG_PAD]) pad_q <= wdata & DMSK;
            if (wr_stb[`BPL_REG_THR] && HAS_THR) thr_q <= wdata[1:0];
        end
    end

    // Peripheral takes over value and direction of claimed lines
    bpl_pkg::bpl_word_t val, drv;
    assign val     = (alt_q & alt_out) | (~alt_q & out_q);
    assign drv     = (alt_q & alt_oe) | (~alt_q & dir_q);
    assign pin_oe  = drv & (~od_q | ~val) & DMSK;
    assign pin_out = val & ~od_q & DMSK;

    assign rd_word = rd_sel == `BPL_REG_OUT ? out_q
                   : rd_sel == `BPL_REG_DIR ? dir_q
                   : rd_sel == `BPL_REG_ODC ? od_q
                   : rd_sel == `BPL_REG_PIN ? pin_q
                   : rd_sel == `BPL_REG_THR ? {14'h0000, thr_q}
                   : rd_sel == `BPL_REG_PAD ? pad_q
                   : rd_sel == `BPL_REG_ALT ? alt_q
                   : 16'h0000;
endmodule : bpl_port_slice

/* logic/bpl_top.sv */
// Parallel port block: APB register file and pad control
// Summary of operation
// - 103 lines: nine bidirectional ports plus one input-only port
// - Each bidirectional line writable alone via set and clear words
// - Every bidirectional line has its own direction bit
// - Input lines stop driving, leaving the pin at high impedance
// - Some ports select push/pull or open-drain per pin
// - During reset all pins are inputs except reset indication output
// - Pad driver control registers hold edge shape and drive current
// - Per-byte input threshold on six ports, TTL or CMOS with hysteresis
// - Lines may be handed to peripherals, others stay general purpose
`timescale 1ns/1ns
`include "bpl_consts.svh"
module bpl_top #(
    parameter int AW = 12
) (
    input  wire logic            ref_clk,     // System clock
    input  wire logic            arst_n,      // Async reset
    input  wire logic [AW-1:0]   paddr,       // APB address
    input  wire logic            psel,        // APB select
    input  wire logic            penable,     // APB enable
    input  wire logic            pwrite,      // APB direction
    input  wire logic [31:0]     pwdata,      // APB write data
    output logic [31:0]          prdata,      // APB read data
    output logic                 pready,      // APB ready
    output logic                 pslverr,     // APB error
    input  wire logic [159:0]    pin_in,      // Pad input levels
    output logic [159:0]         pin_out,     // Pad output values
    output logic [159:0]         pin_oe,      // Pad output enables
    input  wire logic [159:0]    alt_out,     // Peripheral outputs
    input  wire logic [159:0]    alt_oe,      // Peripheral enables
    output logic [159:0]         alt_in,      // Pins to peripherals
    output logic [19:0]          pad_thr_cmos, // Threshold per byte
    output logic [159:0]         pad_driver_control, // Pad shape/current
    output logic                 rst_ind_o,   // Reset indication value
    output logic                 rst_ind_oe   // Reset indication enable
);
    localparam int NP = `BPL_NPORTS;
    localparam int PW = `BPL_PW;
    localparam logic [49:0] LINES = `BPL_LINES;
    localparam logic [9:0] OD_CAP = `BPL_OD_CAP;
    localparam logic [9:0] THR_CAP = `BPL_THR_CAP;

    // Port and register fields must fit the address
    if (AW < `BPL_MAP_TOP)
    begin : g_aw_chk
        $error("bpl_top: AW too small");
    end

    bpl_pkg::bpl_idx_t  port_idx;
    bpl_pkg::bpl_idx_t  reg_idx;
    logic               hit;
    bpl_pkg::bpl_stb_t  wr_stb;
    bpl_pkg::bpl_word_t rd_w  [NP];
    bpl_pkg::bpl_word_t out_v [NP];
    bpl_pkg::bpl_word_t dir_v [NP];
    bpl_pkg::bpl_word_t od_v  [NP];
    bpl_pkg::bpl_word_t alt_v [NP];
    bpl_pkg::bpl_word_t pin_v [NP];
    bpl_pkg::bpl_word_t pad_v [NP];
    logic [1:0]         thr_v [NP];
    logic [31:0]        prdata_r;
    logic [31:0]        prdata_nxt;
    logic               rst_done_r;

    // Address split and write strobes
    bpl_apb_decode #(
        .AW (AW)
    ) u_dec (
        .paddr    (paddr),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .port_idx (port_idx),
        .reg_idx  (reg_idx),
        .hit      (hit),
        .wr_stb   (wr_stb)
    );

    // One slice per port; the input-only port gets no drivers
    for (genvar i = 0; i < NP; i++)
    begin : g_port
        localparam int LN = int'(LINES[i*`BPL_LW +: `BPL_LW]);
        localparam bit IO = (i == `BPL_INPORT);
        bpl_pkg::bpl_stb_t stb_i;
        assign stb_i = (port_idx == 4'(i)) ? wr_stb : 9'h000;
        bpl_port_slice #(
            .LINES   (LN),
            .HAS_OD  (OD_CAP[i]),
            .HAS_THR (THR_CAP[i]),
            .IN_ONLY (IO)
        ) u_slice (
            .ref_clk (ref_clk),
            .arst_n  (arst_n),
            .wr_stb  (stb_i),
            .wdata   (pwdata[PW-1:0]),
            .rd_sel  (reg_idx),
            .pin_in  (pin_in[i*PW +: PW]),
            .alt_out (alt_out[i*PW +: PW]),
            .alt_oe  (alt_oe[i*PW +: PW]),
            .rd_word (rd_w[i]),
            .pin_out (pin_out[i*PW +: PW]),
            .pin_oe  (pin_oe[i*PW +: PW]),
            .pin_q   (pin_v[i]),
            .out_q   (out_v[i]),
            .dir_q   (dir_v[i]),
            .od_q    (od_v[i]),
            .alt_q   (alt_v[i]),
            .thr_q   (thr_v[i]),
            .pad_q   (pad_v[i])
        );
        // Sampled levels feed peripherals whether claimed or not
        assign alt_in[i*PW +: PW]             = pin_v[i];
        assign pad_thr_cmos[2*i +: 2]         = thr_v[i];
        assign pad_driver_control[i*PW +: PW] = pad_v[i];
    end

    // Read word chosen at setup, so access phase sees stable data
    assign prdata_nxt = (psel && !penable && !pwrite && hit)
                      ? {16'h0000, rd_w[port_idx[3:0]]} : prdata_r;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata_r <= 32'h0000_0000;
        else
            prdata_r <= prdata_nxt;
    end

    // Zero wait states; bad addresses answer with an error
    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Reset indication stays an output and shows reset as low
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_done_r <= 1'b0;
        else
            rst_done_r <= 1'b1;
    end
    assign rst_ind_o  = rst_done_r;
    assign rst_ind_oe = 1'b1;

    // Checks on the behaviour seen at the ports
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    logic wr_acc;
    logic rd_set;
    assign wr_acc = psel && penable && pwrite && hit && port_idx == 4'h0;
    assign rd_set = psel && !penable && !pwrite && hit;

    property p_rst_hiz;
        !rst_done_r |-> pin_oe == 160'h0 && rst_ind_oe;
    endproperty
    a_rst_hiz: assert property (p_rst_hiz)
        else $error("pins driven straight after reset");

    property p_dir_wr;
        wr_acc && reg_idx == `BPL_REG_DIR
        |=> dir_v[0] == $past(pwdata[PW-1:0]);
    endproperty
    a_dir_wr: assert property (p_dir_wr)
        else $error("direction write not taken");

    property p_set_bit;
        wr_acc && reg_idx == `BPL_REG_SET
        |=> out_v[0] == ($past(out_v[0]) | $past(pwdata[PW-1:0]));
    endproperty
    a_set_bit: assert property (p_set_bit)
        else $error("bit set disturbed other lines");

    property p_clr_bit;
        wr_acc && reg_idx == `BPL_REG_CLR
        |=> out_v[0] == ($past(out_v[0]) & ~$past(pwdata[PW-1:0]));
    endproperty
    a_clr_bit: assert property (p_clr_bit)
        else $error("bit clear disturbed other lines");

    property p_input_hiz;
        (pin_oe[PW-1:0] & ~dir_v[0] & ~alt_v[0]) == 16'h0000;
    endproperty
    a_input_hiz: assert property (p_input_hiz)
        else $error("input line drives its pin");

    property p_od_low;
        (pin_oe[2*PW +: PW] & od_v[2] & pin_out[2*PW +: PW]) == 16'h0000
        && (pin_oe[2*PW +: PW] & od_v[2] & out_v[2] & ~alt_v[2])
           == 16'h0000;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain line drives high");

    property p_gp_drive;
        (dir_v[0] & ~od_v[0] & ~alt_v[0]
         & (pin_out[PW-1:0] ^ out_v[0])) == 16'h0000;
    endproperty
    a_gp_drive: assert property (p_gp_drive)
        else $error("output pin differs from latch");

    property p_pin_read;
        rd_set && reg_idx == `BPL_REG_PIN
        |=> prdata[PW-1:0] == $past(pin_v[port_idx]) ##1 pready;
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("pin read returned wrong level");

    property p_in_only;
        pin_oe[`BPL_INPORT*PW +: PW] == 16'h0000
        && dir_v[`BPL_INPORT] == 16'h0000;
    endproperty
    a_in_only: assert property (p_in_only)
        else $error("input-only port driven");

    property p_alt_drive;
        (alt_v[0] & ~od_v[0] & alt_oe[PW-1:0]
         & (pin_out[PW-1:0] ^ alt_out[PW-1:0])) == 16'h0000;
    endproperty
    a_alt_drive: assert property (p_alt_drive)
        else $error("claimed line not driven by peripheral");

    property p_thr_wr;
        psel && penable && pwrite && hit && port_idx == 4'h2
        && reg_idx == `BPL_REG_THR
        |=> pad_thr_cmos[5:4] == $past(pwdata[1:0]);
    endproperty
    a_thr_wr: assert property (p_thr_wr)
        else $error("threshold write not taken");

    property p_pad_wr;
        wr_acc && reg_idx == `BPL_REG_PAD
        |=> pad_driver_control[PW-1:0] == $past(pwdata[PW-1:0]);
    endproperty
    a_pad_wr: assert property (p_pad_wr)
        else $error("pad driver control write not taken");

    property p_out_wr;
        wr_acc && reg_idx == `BPL_REG_OUT
        |=> out_v[0] == $past(pwdata[PW-1:0]);
    endproperty
    a_out_wr: assert property (p_out_wr)
        else $error("latch write not taken");

    property p_alt_wr;
        wr_acc && reg_idx == `BPL_REG_ALT
        |=> alt_v[0] == $past(pwdata[PW-1:0]);
    endproperty
    a_alt_wr: assert property (p_alt_wr)
        else $error("alternate select write not taken");

    property p_bad_nowr;
        psel && penable && pwrite && !hit |=> $stable(out_v[0]);
    endproperty
    a_bad_nowr: assert property (p_bad_nowr)
        else $error("refused write changed a latch");

    // Guarded by reset done, since the first sample follows release
    property p_pin_smp;
        rst_done_r |-> pin_v[0] == $past(pin_in[PW-1:0]);
    endproperty
    a_pin_smp: assert property (p_pin_smp)
        else $error("sampled pin level lags or is lost");

    property p_rd_hold;
        !rd_set |=> $stable(prdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved outside a read setup");

    property p_od_none;
        od_v[0] == 16'h0000 && od_v[1] == 16'h0000
        && od_v[`BPL_INPORT] == 16'h0000;
    endproperty
    a_od_none: assert property (p_od_none)
        else $error("open-drain set on a port without it");

    property p_thr_none;
        pad_thr_cmos[1:0] == 2'h0 && pad_thr_cmos[3:2] == 2'h0
        && pad_thr_cmos[2*`BPL_INPORT +: 2] == 2'h0
        && pad_thr_cmos[19:18] == 2'h0;
    endproperty
    a_thr_none: assert property (p_thr_none)
        else $error("threshold set on a port without it");

    property p_line_cnt;
        out_v[2][PW-1] == 1'b0 && out_v[3][PW-1:8] == 8'h00
        && out_v[8][PW-1:4] == 12'h000 && pin_v[9][PW-1:4] == 12'h000;
    endproperty
    a_line_cnt: assert property (p_line_cnt)
        else $error("bit beyond the port's last line");

    property p_rst_regs;
        !rst_done_r |-> out_v[0] == 16'h0000 && dir_v[2] == 16'h0000
        && alt_v[3] == 16'h0000 && prdata == 32'h0000_0000;
    endproperty
    a_rst_regs: assert property (p_rst_regs)
        else $error("register not cleared by reset");

    property p_rst_ind;
        rst_done_r |=> rst_ind_o && rst_ind_oe;
    endproperty
    a_rst_ind: assert property (p_rst_ind)
        else $error("reset indication dropped outside reset");
endmodule : bpl_top

/* testbench/bpl_pin_model.sv */
// Board side of the port pins: pull-ups and outside drivers
`timescale 1ns/1ns
module bpl_pin_model (
    input  wire logic [159:0] pin_out, // Device pad values
    input  wire logic [159:0] pin_oe,  // Device pad enables
    input  wire logic [159:0] ext_val, // Outside driver values
    input  wire logic [159:0] ext_en,  // Outside driver enables
    output logic [159:0]      pin_in   // Resolved pin levels
);
    // Released lines rise on the pull-up, which also lifts open-drain
    // highs; a drive clash reads unknown so it cannot pass unseen
    always_comb
    begin
        for (int i = 0; i < 160; i++)
            pin_in[i] = (pin_oe[i] && ext_en[i]) ? 1'bx :
                        pin_oe[i] ? pin_out[i] :
                        ext_en[i] ? ext_val[i] : 1'b1;
    end
endmodule : bpl_pin_model

/* testbench/tb_bpl_top.sv */
// Self-checking bench for the parallel port block
`timescale 1ns/1ns
`include "bpl_consts.svh"
module tb_bpl_top;
    logic         ref_clk, arst_n, psel, penable, pwrite, perr;
    logic         pready, pslverr, rst_ind_o, rst_ind_oe;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rdat;
    logic [159:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
    logic [159:0] pad_driver_control, ext_val, ext_en;
    logic [19:0]  pad_thr_cmos;
    int           err_total, cmp_count;

    bpl_top #(.AW(12)) u_bpl_top (.ref_clk, .arst_n, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .pin_in,
        .pin_out, .pin_oe, .alt_out, .alt_oe, .alt_in, .pad_thr_cmos,
        .pad_driver_control, .rst_ind_o, .rst_ind_oe);
    bpl_pin_model u_bpl_pin_model (.pin_out, .pin_oe, .ext_val, .ext_en,
        .pin_in);

    // Free-running 250 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task report_and_stop();
        $display("mismatches %0d in %0d compares", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    task chk(input logic [159:0] got, input logic [159:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [11:0] ad(input int p, input int r);
        return 12'(p * 64 + r * 4);
    endfunction : ad

    // One APB transfer; request held until pready seen at an edge
    task apb(input logic [11:0] a, input logic w, input logic [15:0] d);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : apb

    task wr(input int p, input int r, input logic [15:0] d);
        apb(ad(p, r), 1'b1, d);
    endtask : wr

    task rd(input int p, input int r);
        apb(ad(p, r), 1'b0, 16'h0000);
    endtask : rd

    // Reset held 12 cycles; outputs are checked while it is low
    task t_reset();
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        chk(pin_oe, '0);
        chk({rst_ind_o, rst_ind_oe}, 2'b01);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({rst_ind_o, rst_ind_oe}, 2'b11);
    endtask : t_reset

    // Set and clear words touch single bits; pins follow the latch
    task t_gpio();
        wr(0, `BPL_REG_DIR, 16'hffff);
        wr(0, `BPL_REG_OUT, 16'ha5a5);
        wr(0, `BPL_REG_SET, 16'h0a00);
        wr(0, `BPL_REG_CLR, 16'h0005);
        #1 chk(pin_out[15:0], 16'hafa0);
        chk(pin_oe[15:0], 16'hffff);
        rd(0, `BPL_REG_OUT);
        chk(rdat, 32'h0000afa0);
        rd(0, `BPL_REG_SET);
        chk(rdat, 32'h0);
        wr(0, `BPL_REG_DIR, 16'h00f0);
        #1 chk(pin_oe[15:0], 16'h00f0);
        repeat (2) @(posedge ref_clk);
        rd(0, `BPL_REG_PIN);
        chk(rdat, 32'h0000ffaf);
    endtask : t_gpio

    // Unmapped and unaligned places refuse and leave the latch alone
    task t_err();
        apb(12'h400, 1'b1, 16'hffff);
        chk(perr, 1'b1);
        apb(ad(0, `BPL_REG_OUT) | 12'h001, 1'b1, 16'h0000);
        chk(perr, 1'b1);
        rd(0, `BPL_REG_OUT);
        chk({perr, rdat}, 33'h00000afa0);
    endtask : t_err

    // Open-drain lines drive only lows; pull-up supplies the highs
    task t_od();
        wr(2, `BPL_REG_DIR, 16'h7fff);
        wr(2, `BPL_REG_ODC, 16'h00ff);
        wr(2, `BPL_REG_OUT, 16'h0f0f);
        #1 chk(pin_oe[47:32], 16'h7ff0);
        repeat (2) @(posedge ref_clk);
        rd(2, `BPL_REG_PIN);
        chk(rdat, 32'h00000f0f);
        wr(0, `BPL_REG_ODC, 16'hffff);
        rd(0, `BPL_REG_ODC);
        chk(rdat, 32'h0);
    endtask : t_od

    // Line count per port seen through the output latch width
    task t_lines();
        int n[10];
        n = '{16, 16, 15, 8, 8, 0, 8, 8, 4, 4};
        for (int p = 0; p < 10; p++)
        begin
            wr(p, `BPL_REG_OUT, 16'hffff);
            rd(p, `BPL_REG_OUT);
            chk(rdat, (32'h1 << n[p]) - 32'h1);
        end
    endtask : t_lines

    // Pad word and byte thresholds reach their outputs
    task t_pad();
        wr(1, `BPL_REG_PAD, 16'h1234);
        wr(2, `BPL_REG_THR, 16'h0001);
        wr(0, `BPL_REG_THR, 16'h0003);
        #1 chk(pad_driver_control[31:16], 16'h1234);
        chk(pad_thr_cmos[5:0], 6'h10);
        rd(1, `BPL_REG_PAD);
        chk(rdat, 32'h00001234);
        rd(2, `BPL_REG_THR);
        chk(rdat, 32'h00000001);
    endtask : t_pad

    // Input-only port never drives but reports outside levels
    task t_inonly();
        @(posedge ref_clk);
        ext_en[95:80]  <= 16'hffff;
        ext_val[95:80] <= 16'h3c5a;
        wr(5, `BPL_REG_DIR, 16'hffff);
        #1 chk(pin_oe[95:80], 16'h0000);
        rd(5, `BPL_REG_DIR);
        chk(rdat, 32'h0);
        rd(5, `BPL_REG_PIN);
        chk(rdat, 32'h00003c5a);
        chk(alt_in[95:80], 16'h3c5a);
        ext_en <= '0;
    endtask : t_inonly

    // Alternate select hands value and drive to the peripheral
    task t_alt();
        @(posedge ref_clk);
        alt_out[63:48] <= 16'h00a5;
        alt_oe[63:48]  <= 16'h00ff;
        wr(3, `BPL_REG_ALT, 16'h00ff);
        #1 chk({pin_oe[63:48], pin_out[55:48]}, 24'h00ffa5);
        rd(3, `BPL_REG_ALT);
        chk(rdat, 32'h000000ff);
        wr(3, `BPL_REG_ALT, 16'h0000);
        #1 chk(pin_oe[63:48], 16'h0000);
    endtask : t_alt

    initial
    begin
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {alt_out, alt_oe, ext_val, ext_en} = '0;
        err_total = 0;
        cmp_count = 0;
        t_reset();
        t_gpio();
        t_err();
        t_od();
        t_lines();
        t_pad();
        t_inonly();
        t_alt();
        wr(0, `BPL_REG_DIR, 16'hffff);
        t_reset();
        rd(0, `BPL_REG_DIR);
        chk(rdat, 32'h0);
        report_and_stop();
    end
endmodule : tb_bpl_top
